/* fpsg_pkg.sv */
// fpsg_pkg: constants for the front-panel step and loader guard block.
// assumes a 100 MHz system clock and one-clock timing strobes from the timing generator.
package fpsg_pkg;
  // system clock
  localparam int CLK_PERIOD_NS      = 10;
  // machine timing
  localparam int MACHINE_CYCLE_NS   = 1600;
  localparam int STEP_PULSE_NS      = 1400;
  localparam int BASIC_PULSE_MIN_NS = 45;
  localparam int BASIC_PULSE_MAX_NS = 55;
  localparam int MACHINE_CYCLE_CYC  = MACHINE_CYCLE_NS / CLK_PERIOD_NS;
  localparam int STEP_PULSE_CYC     = STEP_PULSE_NS / CLK_PERIOD_NS;
  // basic pulse spans at least one system clock
  localparam int BASIC_PULSE_CYC    = (BASIC_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // memory address space and loader area
  localparam int ADDR_W             = 16;
  localparam int GUARD_WORDS        = 64;
  localparam logic [15:0] SAMPLE_GUARD_ADDR = 16'hFFF8;
  // reset values
  localparam logic FLAG_CLEAR       = 1'b0;
  localparam logic INHIBIT_IDLE_N   = 1'b1;
endpackage

/* fpsg_guard_decode.sv */
// fpsg_guard_decode: registered decode of the loader area at the top of memory.
// assumes mem_addr is stable for the machine cycle in which it is used.
`timescale 1ns/1ns
module fpsg_guard_decode #(
  parameter int ADDR_W      = fpsg_pkg::ADDR_W,
  parameter int GUARD_WORDS = fpsg_pkg::GUARD_WORDS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // address and selection
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              loader_guard_select,
  // decode results
  output logic                   in_guard_area_r,
  output logic                   guard_inhibit_n_r
);
  localparam int LOW_W = $clog2(GUARD_WORDS);

  if (GUARD_WORDS < 2 || (1 << LOW_W) != GUARD_WORDS || LOW_W >= ADDR_W) begin : g_bad
    $error("guard area must be a power of two smaller than memory");
  end

  logic in_area_nxt;
  logic inhibit_n_nxt;

  always_comb begin
    in_area_nxt   = &mem_addr[ADDR_W-1:LOW_W];
    inhibit_n_nxt = ~(in_area_nxt & loader_guard_select);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      in_guard_area_r   <= fpsg_pkg::FLAG_CLEAR;
      guard_inhibit_n_r <= fpsg_pkg::INHIBIT_IDLE_N;
    end else begin
      in_guard_area_r   <= in_area_nxt;
      guard_inhibit_n_r <= inhibit_n_nxt;
    end
  end
endmodule // fpsg_guard_decode

/* fpsg_step_guard.sv */
// fpsg_step_guard: single machine-cycle step from a momentary switch, and loader-area
// memory guard that drops the memory timing enable.
// assumes phase_time_one, phase_time_two and cycle_pulse are one-clock strobes, each
// once per machine cycle, with cycle_pulse falling between phase_time_two and the
// following phase_time_one.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - step_request is true while the step switch is held with the run flag clear, and false once released or while running.
// - each press gives exactly one step-gate pulse, from a phase_time_two to the next phase_time_one.
// - each press sets the run flag for one machine cycle, then clears it to halt.
// - phase-transfer enable is true for the one machine cycle of the step.
// - the run flag only changes on the basic timing pulse recurring each machine cycle.
// - loader_guard_select follows the loader switch: true when protected.
// - guard_inhibit_n goes low only for a top-64 address while protection is selected.
// - while guard_inhibit_n is low the memory timing enable is forced false.
// - with protection on and an address below the top 64, memory access proceeds.
// - an address such as octal 177770 is inside the protected area.
// - the step switch has no effect unless the machine is halted.
// - stage one sets at the first phase_time_two after a press and clears at the first after release.
module fpsg_step_guard #(
  parameter int ADDR_W      = fpsg_pkg::ADDR_W,
  parameter int GUARD_WORDS = fpsg_pkg::GUARD_WORDS
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // front panel switches
  input  wire logic              step_switch,
  input  wire logic              loader_switch_protected,
  // timing strobes
  input  wire logic              phase_time_one,
  input  wire logic              phase_time_two,
  input  wire logic              cycle_pulse,
  // memory side
  input  wire logic [ADDR_W-1:0] mem_addr,
  input  wire logic              mem_enable_others,
  // step outputs
  output logic                   step_request,
  output logic                   step_stage_one,
  output logic                   step_gate,
  output logic                   run_flag_second,
  output logic                   phase_transfer_enable,
  output logic                   halt_indicator,
  // guard outputs
  output logic                   loader_guard_select,
  output logic                   guard_inhibit_n,
  output logic                   memory_timing_enable
);
  ////////////////////////////////////////////////////////////////////////////////
  // step sequence
  logic step_request_r, step_request_nxt;
  logic stage_one_r,    stage_one_nxt;
  logic stage_two_r,    stage_two_nxt;
  logic step_gate_r,    step_gate_nxt;
  logic run_r,          run_nxt;
  logic halt_r,         halt_nxt;

  always_comb begin
    step_request_nxt = step_switch & ~run_r;
    stage_one_nxt    = stage_one_r;
    if (phase_time_two) begin
      // once set it holds until release, so the run-time disable cannot re-arm it
      stage_one_nxt = step_switch & (stage_one_r | step_request_r);
    end
    stage_two_nxt = stage_two_r;
    if (phase_time_one) begin
      stage_two_nxt = stage_one_r;
    end
    step_gate_nxt = stage_one_nxt & ~stage_two_nxt;
    run_nxt       = run_r;
    if (cycle_pulse) begin
      run_nxt = step_gate_r;
    end
    halt_nxt      = ~run_nxt;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_request_r <= fpsg_pkg::FLAG_CLEAR;
      stage_one_r    <= fpsg_pkg::FLAG_CLEAR;
      stage_two_r    <= fpsg_pkg::FLAG_CLEAR;
      step_gate_r    <= fpsg_pkg::FLAG_CLEAR;
      run_r          <= fpsg_pkg::FLAG_CLEAR;
      halt_r         <= ~fpsg_pkg::FLAG_CLEAR;
    end else begin
      step_request_r <= step_request_nxt;
      stage_one_r    <= stage_one_nxt;
      stage_two_r    <= stage_two_nxt;
      step_gate_r    <= step_gate_nxt;
      run_r          <= run_nxt;
      halt_r         <= halt_nxt;
    end
  end

  assign step_request          = step_request_r;
  assign step_stage_one        = stage_one_r;
  assign step_gate             = step_gate_r;
  assign run_flag_second       = run_r;
  assign phase_transfer_enable = run_r;
  assign halt_indicator        = halt_r;

  ////////////////////////////////////////////////////////////////////////////////
  // loader guard
  logic select_r,     select_nxt;
  logic mem_timing_r, mem_timing_nxt;
  logic in_area_r;
  logic inhibit_n_r;

  fpsg_guard_decode #(
    .ADDR_W      (ADDR_W),
    .GUARD_WORDS (GUARD_WORDS)
  ) u_decode (
    .clk                 (clk),
    .reset_n             (reset_n),
    .mem_addr            (mem_addr),
    .loader_guard_select (select_r),
    .in_guard_area_r     (in_area_r),
    .guard_inhibit_n_r   (inhibit_n_r)
  );

  always_comb begin
    select_nxt     = loader_switch_protected;
    mem_timing_nxt = inhibit_n_r & mem_enable_others;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      select_r     <= fpsg_pkg::FLAG_CLEAR;
      mem_timing_r <= fpsg_pkg::FLAG_CLEAR;
    end else begin
      select_r     <= select_nxt;
      mem_timing_r <= mem_timing_nxt;
    end
  end

  assign loader_guard_select  = select_r;
  assign guard_inhibit_n      = inhibit_n_r;
  assign memory_timing_enable = mem_timing_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  localparam int LOW_W = $clog2(GUARD_WORDS);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // a step: gate open at the basic pulse, then the run flag stands alone
  sequence s_gate_open;
    step_gate_r && cycle_pulse;
  endsequence
  sequence s_run_one_cycle;
    run_r && !cycle_pulse;
  endsequence
  // a guarded access: decode answers one clock later, the timing enable one after
  sequence s_guard_hit;
    select_r && mem_addr == fpsg_pkg::SAMPLE_GUARD_ADDR;
  endsequence
  sequence s_guard_blocked;
    !inhibit_n_r ##1 !mem_timing_r;
  endsequence

  // step request and stage one
  a_request_held: assert property (step_switch && !run_r |=> step_request_r)
    else $error("step request missing while switch held in halt");
  a_request_halted: assert property (run_r |=> !step_request_r)
    else $error("step request raised while running");
  a_request_drops: assert property (!step_switch |=> !step_request_r)
    else $error("step request still raised after release");
  a_stage_sets_t2: assert property (phase_time_two && step_switch && step_request_r
                                    |=> stage_one_r)
    else $error("stage one not set at phase two");
  a_stage_clears_t2: assert property (phase_time_two && !step_switch
                                      |=> !stage_one_r)
    else $error("stage one not cleared after release");

  // step gate
  a_gate_rises_t2: assert property ($rose(step_gate_r)
                                    |-> $past(phase_time_two))
    else $error("step gate opened off phase two");
  a_gate_closes_t1: assert property (step_gate_r && phase_time_one |=> !step_gate_r)
    else $error("step gate still open after phase one");
  a_gate_falls_t1: assert property ($fell(step_gate_r)
                                    |-> $past(phase_time_one))
    else $error("step gate closed off phase one");
  a_stage_two_t1: assert property (phase_time_one
                                   |=> stage_two_r == $past(stage_one_r))
    else $error("stage two did not follow stage one at phase one");
  a_gate_no_rearm: assert property (stage_two_r && step_switch |=> !step_gate_r)
    else $error("second step gate while switch held");

  // run flag and phase transfer
  a_run_single: assert property (s_gate_open |=> s_run_one_cycle)
    else $error("run flag not set by step gate");
  a_run_rises: assert property ($rose(run_r)
                                |-> $past(cycle_pulse) && $past(step_gate_r))
    else $error("run flag set without a step gate");
  a_run_drops: assert property (run_r && cycle_pulse && !step_gate_r |=> !run_r)
    else $error("run flag held beyond one machine cycle");
  a_run_steady: assert property (!cycle_pulse |=> $stable(run_r))
    else $error("run flag changed off the basic pulse");
  a_phase_enable: assert property (phase_transfer_enable == run_r
                                   && halt_indicator != run_r)
    else $error("phase enable does not follow run flag");

  // loader guard
  a_select_follow: assert property (loader_switch_protected |=> loader_guard_select)
    else $error("guard select not following switch");
  a_select_clear: assert property (!loader_switch_protected
                                   |=> !loader_guard_select)
    else $error("guard select held after switch enabled");
  a_guard_blocks: assert property (s_guard_hit |=> s_guard_blocked)
    else $error("top address not blocked under protection");
  a_guard_passes: assert property (select_r && !(&mem_addr[ADDR_W-1:LOW_W])
                                   |=> inhibit_n_r)
    else $error("inhibit raised outside the loader area");
  a_inhibit_area: assert property (!inhibit_n_r
                                   |-> in_area_r && $past(select_r))
    else $error("inhibit low outside a selected loader area");
  a_timing_blocked: assert property (!inhibit_n_r |=> !mem_timing_r)
    else $error("memory timing enabled while inhibited");
  a_timing_and: assert property (inhibit_n_r && mem_enable_others |=> mem_timing_r)
    else $error("memory timing enable missing");
endmodule // fpsg_step_guard

/* fpsg_timing_model.sv */
// fpsg_timing_model: timing generator strobes that drive the step and guard block.
// assumes the 100 MHz clock and the machine cycle length of fpsg_pkg.
`timescale 1ns/1ns
module fpsg_timing_model (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // strobes: phase two, then basic pulse, then phase one
  output logic      phase_time_one,
  output logic      phase_time_two,
  output logic      cycle_pulse
);
  int cnt_r;
  always_ff @(posedge clk) begin
    if (!reset_n) cnt_r <= 0;
    else cnt_r <= (cnt_r == fpsg_pkg::MACHINE_CYCLE_CYC - 1) ? 0 : cnt_r + 1;
    phase_time_two <= reset_n && cnt_r == 0;
    cycle_pulse    <= reset_n && cnt_r == 10;
    phase_time_one <= reset_n && cnt_r == fpsg_pkg::STEP_PULSE_CYC;
  end
endmodule // fpsg_timing_model

/* tb.sv */
// tb: self-checking bench for the step and guard block.
// assumes fpsg_timing_model supplies the strobes once per machine cycle.
`timescale 1ns/1ns
module tb;
  logic        clk = 1'b0, reset_n = 1'b0, step_switch = 1'b0;
  logic        loader_switch_protected = 1'b0, mem_enable_others = 1'b1;
  logic [15:0] mem_addr = 16'h0000;
  logic        ph1, ph2, cp, sreq, s1, sgate, run, pte, halt, sel, inh_n, tim_en;
  int          miscompares = 0, n_tests = 0;
  int          exp_q[$];
  logic [31:0] seed = 32'h0001843D;
  initial forever #5 clk = ~clk;
  fpsg_timing_model tm (.clk(clk), .reset_n(reset_n), .phase_time_one(ph1),
    .phase_time_two(ph2), .cycle_pulse(cp));
  fpsg_step_guard DUT (.clk(clk), .reset_n(reset_n), .step_switch(step_switch),
    .loader_switch_protected(loader_switch_protected), .phase_time_one(ph1),
    .phase_time_two(ph2), .cycle_pulse(cp), .mem_addr(mem_addr),
    .mem_enable_others(mem_enable_others), .step_request(sreq), .step_stage_one(s1),
    .step_gate(sgate), .run_flag_second(run), .phase_transfer_enable(pte),
    .halt_indicator(halt), .loader_guard_select(sel), .guard_inhibit_n(inh_n),
    .memory_timing_enable(tim_en));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic conclude();
    $display("counts: %0d compares, %0d mismatches", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic pop_cmp(input int w, input string msg);
    if (exp_q.size() == 0) check(1, 0, {"unexpected ", msg});
    else check(w, exp_q.pop_front(), msg);
  endtask
  task automatic wait_run(input logic lvl);
    for (int i = 0; i < 400; i++) begin
      @(posedge clk);
      #1;
      if (run === lvl) return;
    end
    check(0, 1, "run flag wait timed out");
    conclude();
  endtask
  task automatic guard_case(input logic [15:0] a, input logic p, input logic o);
    logic e;
    @(posedge clk);
    mem_addr <= a;
    loader_switch_protected <= p;
    mem_enable_others <= o;
    repeat (3) @(posedge clk);
    #1;
    e = !(p && a[15:6] == 10'h3FF);
    check(sel, p, "guard select");
    check(inh_n, e, "guard inhibit");
    check(tim_en, e & o, "timing enable");
  endtask
  // one press; busy_press retries the switch while running and expects no effect
  task automatic press(input int hold, input logic busy_press);
    @(posedge clk);
    step_switch <= 1'b1;
    exp_q.push_back(fpsg_pkg::STEP_PULSE_CYC);
    exp_q.push_back(fpsg_pkg::MACHINE_CYCLE_CYC);
    repeat (2) @(posedge clk);
    #1;
    check(sreq, 1'b1, "request while held");
    wait_run(1'b1);
    check(s1, 1'b1, "stage one while stepping");
    repeat (hold + 1) @(posedge clk);
    step_switch <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check(sreq, 1'b0, "request after release");
    if (busy_press) begin
      @(posedge clk);
      step_switch <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      check(sreq, 1'b0, "request while running");
      @(posedge clk);
      step_switch <= 1'b0;
    end
    wait_run(1'b0);
    repeat (2 * fpsg_pkg::MACHINE_CYCLE_CYC) @(posedge clk);
    #1;
    check(s1, 1'b0, "stage one after release");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin : watch
    int wg, wr;
    wg = 0;
    wr = 0;
    forever begin
      @(posedge clk);
      #1;
      if (sgate === 1'b1) wg++;
      else if (wg > 0) begin
        pop_cmp(wg, "step gate width");
        wg = 0;
      end
      if (run === 1'b1) begin
        wr++;
        check({pte, halt}, 2'h2, "transfer enable and halt");
      end else begin
        check({pte, halt}, 2'h1, "transfer enable and halt at rest");
        if (wr > 0) begin
          pop_cmp(wr, "run flag width");
          wr = 0;
        end
      end
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    guard_case(16'hFFF8, 1'b1, 1'b1);
    guard_case(16'hFFBF, 1'b1, 1'b1);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr_next(seed);
      guard_case(seed[0] ? (seed[31:16] | 16'hFFC0) : seed[31:16], seed[1], |seed[3:2]);
    end
    $display("guard test done");
    press(0, 1'b0);
    press(3 * fpsg_pkg::MACHINE_CYCLE_CYC, 1'b0);
    press(0, 1'b1);
    check(exp_q.size(), 0, "missing pulses");
    $display("step test done");
    conclude();
  end
endmodule // tb
